// [logic/bc_msg_regs.svh]
`ifndef BC_MSG_REGS_SVH
`define BC_MSG_REGS_SVH

// message control word fields
`define CTRL_MSG_ERR_MASK 14
`define CTRL_SREQ_MASK 13
`define CTRL_BUSY_MASK 12
`define CTRL_SUBSYS_MASK 11
`define CTRL_TFLAG_MASK 10
`define CTRL_RSV_MASK 9
`define CTRL_RETRY 8
`define CTRL_CHAN_A 7
`define CTRL_SELF_TEST 6
`define CTRL_BCAST_EXPECT 5
`define CTRL_MSG_END_IRQ_ENABLE 4
`define CTRL_LEGACY 3

// received terminal status word fields
`define STS_ADDR_HI 15
`define STS_ADDR_LO 11
`define STS_MSG_ERR 10
`define STS_SREQ 8
`define STS_RSV_HI 7
`define STS_RSV_LO 5
`define STS_BCAST_RCVD 4
`define STS_BUSY 3
`define STS_SUBSYS 2
`define STS_TFLAG 0
`define STS_RSV_BITS 11'h0e0

// command word fields
`define CMD_TX 10
`define CMD_MODE_MSB 4

// block status word fields
`define BSW_END_OF_MESSAGE_FLAG 15
`define BSW_START_OF_MESSAGE_FLAG 14
`define BSW_CHAN_B 13
`define BSW_ERROR 12
`define BSW_STATUS_SET 11
`define BSW_FORMAT_ERR 10
`define BSW_TIMEOUT 9
`define BSW_LOOP_FAIL 8
`define BSW_FILTERED_STATUS_FLAG 7
`define BSW_RETRY_CNT1 6
`define BSW_RETRY_CNT0 5
`define BSW_GOOD_BLOCK 4
`define BSW_WRONG_ADDR 3
`define BSW_WC_ERR 2
`define BSW_SYNC_ERR 1
`define BSW_INVALID_WORD 0
`define BSW_LOW_LEGACY 8'hff

`define MAX_WORD_COUNT 6'd32

`endif

// [logic/bc_msg_pkg.sv]
package bc_msg_pkg;

    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_WCTRL = 4'h1,
        S_SOM = 4'h2,
        S_FETCH = 4'h3,
        S_FWAIT = 4'h4,
        S_ECHO = 4'h5,
        S_LOOPWR = 4'h6,
        S_RX = 4'h7,
        S_END = 4'h8,
        S_BSW = 4'h9
    } bc_state_t;

    typedef enum logic [2:0] {
        F_XFER = 3'h0,
        F_RTRT = 3'h1,
        F_BCAST = 3'h2,
        F_BCRTRT = 3'h3,
        F_MODE = 3'h4,
        F_BCMODE = 3'h6,
        F_UNUSED = 3'h7
    } msg_fmt_t;

    typedef struct packed {
        logic enhancedMode;
        logic extendedCtrlWordEnable;
        logic retryEnable;
        logic doubleRetry;
        logic [1:0] retryAltChan;
        logic retryOnLegacyMsgError;
        logic retryOnStatusSet;
        logic bcastMaskMode;
        logic msgIrqMaskBit;
    } cfg_t;

    typedef struct packed {
        logic cmdSync;
        logic [15:0] data;
    } bus_word_t;

    typedef struct packed {
        logic valid;
        logic cmdSync;
        logic invalid;
        logic [15:0] data;
    } rx_word_t;

    typedef struct packed {
        bc_state_t state;
        logic ramRe;
        logic ramWe;
        logic [15:0] ramAddr;
        logic [15:0] ramWdata;
        logic [15:0] ptr;
        logic [15:0] base;
        logic [15:0] desc;
        logic [15:0] ctrl;
        logic [15:0] cmd1;
        logic [15:0] cmd2;
        logic [15:0] lastTx;
        logic [15:0] lastEcho;
        logic [5:0] txIdx;
        logic [5:0] txTotal;
        logic [5:0] echoCnt;
        logic [5:0] rxIdx;
        logic [5:0] rxTotal;
        logic [5:0] rxData;
        logic [1:0] retries;
        logic [1:0] bufCnt;
        bus_word_t buf0;
        bus_word_t buf1;
        logic txValid;
        logic chanA;
        logic inhibit;
        logic busy;
        logic done;
        logic irq;
        logic loopFail;
        logic sSet;
        logic mSet;
        logic fmtErr;
        logic tmo;
        logic wAddr;
        logic wcErr;
        logic syncErr;
        logic invWord;
        logic msgErr;
    } bc_regs_t;

endpackage : bc_msg_pkg

// [logic/bc_message_control.sv]
`timescale 1ns/1ps
`include "bc_msg_regs.svh"
module bc_message_control
    import bc_msg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic start,
    input wire logic [15:0] msgAddr,
    input wire logic [15:0] descAddr,
    input wire cfg_t cfg,
    output logic ramRe,
    output logic ramWe,
    output logic [15:0] ramAddr,
    output logic [15:0] ramWdata,
    input wire logic [15:0] ramRdata,
    input wire logic ramRvalid,
    output logic txValid,
    output bus_word_t txWord,
    input wire logic txReady,
    output logic txChanA,
    output logic txInhibit,
    input wire rx_word_t rxWord,
    input wire logic rspTimeout,
    output logic busy,
    output logic msgDone,
    output logic irqReq
);

    bc_regs_t r_q, r_d;

    function automatic msg_fmt_t decodeFmt(input logic [2:0] code);
        case (code)
            3'h0: decodeFmt = F_XFER;
            3'h1: decodeFmt = F_RTRT;
            3'h2: decodeFmt = F_BCAST;
            3'h3: decodeFmt = F_BCRTRT;
            3'h4: decodeFmt = F_MODE;
            3'h6: decodeFmt = F_BCMODE;
            default: decodeFmt = F_UNUSED;
        endcase
    endfunction : decodeFmt

    function automatic logic [5:0] wordCount(input logic [15:0] cmd);
        wordCount = (cmd[4:0] == 5'h00) ? `MAX_WORD_COUNT : {1'b0, cmd[4:0]};
    endfunction : wordCount

    // data words going out (dirTx=1) or coming back for one command
    function automatic logic [5:0] dataCount(input logic [15:0] cmd, input logic isMode,
                                             input logic legacy, input logic dirTx);
        logic rtSends;
        rtSends = cmd[`CMD_TX];
        if (isMode)
            dataCount = ((rtSends != dirTx) && cmd[`CMD_MODE_MSB] && !legacy) ? 6'd1 : 6'd0;
        else
            dataCount = (rtSends != dirTx) ? wordCount(cmd) : 6'd0;
    endfunction : dataCount

    // returns {status set, filtered status, address mismatch}
    function automatic logic [2:0] statusEval(input logic [15:0] sw, input logic [15:0] cmd,
                                              input logic [15:0] ctrl, input cfg_t c,
                                              input logic ext);
        logic mism, bcMis, lowSet, filt;
        mism = sw[`STS_ADDR_HI:`STS_ADDR_LO] != cmd[15:11];
        if (ext && c.bcastMaskMode)
            bcMis = !ctrl[`CTRL_BCAST_EXPECT] && sw[`STS_BCAST_RCVD];
        else
            bcMis = sw[`STS_BCAST_RCVD] ^ ctrl[`CTRL_BCAST_EXPECT];
        lowSet = |(sw[10:0] & ~(11'h010 | (ext ? 11'h000 : `STS_RSV_BITS)));
        filt = ext && ((!ctrl[`CTRL_MSG_ERR_MASK] && sw[`STS_MSG_ERR])
            || (!ctrl[`CTRL_SREQ_MASK] && sw[`STS_SREQ])
            || (!ctrl[`CTRL_BUSY_MASK] && sw[`STS_BUSY])
            || (!ctrl[`CTRL_SUBSYS_MASK] && sw[`STS_SUBSYS])
            || (!ctrl[`CTRL_TFLAG_MASK] && sw[`STS_TFLAG])
            || (!ctrl[`CTRL_RSV_MASK] && |sw[`STS_RSV_HI:`STS_RSV_LO])
            || (c.bcastMaskMode && bcMis));
        statusEval = {mism || lowSet || bcMis, filt, mism};
    endfunction : statusEval

    logic ext, legacy, rtrt, bcast, isMode, isStat, retryOk;
    msg_fmt_t fmt;
    logic [2:0] ev;
    logic [5:0] tot, wc;
    logic [15:0] bsw;
    bus_word_t pushWord;

    always_comb begin
        r_d = r_q;
        ev = 3'h0;
        tot = 6'd0;
        wc = 6'd0;
        bsw = 16'h0000;
        isStat = 1'b0;
        pushWord = '0;
        r_d.ramRe = 1'b0;
        r_d.ramWe = 1'b0;
        r_d.done = 1'b0;
        r_d.irq = 1'b0;
        // expanded fields count only with both enables
        ext = cfg.enhancedMode && cfg.extendedCtrlWordEnable;
        legacy = ext && r_q.ctrl[`CTRL_LEGACY];
        fmt = decodeFmt(r_q.ctrl[2:0]);
        rtrt = (fmt == F_RTRT) || (fmt == F_BCRTRT);
        bcast = (fmt == F_BCAST) || (fmt == F_BCRTRT) || (fmt == F_BCMODE);
        isMode = (fmt == F_MODE) || (fmt == F_BCMODE);
        retryOk = ext && cfg.retryEnable && r_q.ctrl[`CTRL_RETRY]
            && (r_q.retries < (cfg.doubleRetry ? 2'd2 : 2'd1))
            && (r_q.tmo || r_q.fmtErr
                || (cfg.retryOnLegacyMsgError && legacy && r_q.msgErr)
                || (cfg.retryOnStatusSet && (r_q.mSet || r_q.wAddr)));
        if (r_q.txValid && txReady) begin
            r_d.buf0 = r_q.buf1;
            r_d.bufCnt = r_q.bufCnt - 2'd1;
        end
        case (r_q.state)
            S_IDLE: begin
                if (start) begin
                    r_d.base = msgAddr;
                    r_d.desc = descAddr;
                    r_d.ramAddr = msgAddr;
                    r_d.ramRe = 1'b1;
                    r_d.busy = 1'b1;
                    r_d.retries = 2'd0;
                    r_d.state = S_WCTRL;
                end
            end
            S_WCTRL: begin
                if (ramRvalid) begin
                    r_d.ctrl = ramRdata;
                    r_d.chanA = ramRdata[`CTRL_CHAN_A];
                    r_d.inhibit = ramRdata[`CTRL_SELF_TEST];
                    r_d.state = S_SOM;
                end
            end
            S_SOM: begin
                r_d.ramWe = 1'b1;
                r_d.ramAddr = r_q.desc;
                r_d.ramWdata = 16'h0000;
                r_d.ramWdata[`BSW_START_OF_MESSAGE_FLAG] = 1'b1;
                r_d.ramWdata[`BSW_CHAN_B] = !r_q.chanA;
                r_d.ptr = r_q.base + 16'd1;
                r_d.txIdx = 6'd0;
                r_d.txTotal = 6'd1;
                r_d.echoCnt = 6'd0;
                r_d.rxIdx = 6'd0;
                {r_d.loopFail, r_d.sSet, r_d.mSet, r_d.tmo, r_d.wAddr} = 5'h00;
                {r_d.wcErr, r_d.syncErr, r_d.invWord, r_d.msgErr} = 4'h0;
                // unused codes end the message as a format error
                r_d.fmtErr = (fmt == F_UNUSED);
                r_d.state = (fmt == F_UNUSED) ? S_END : S_FETCH;
            end
            S_FETCH: begin
                if (r_d.bufCnt != 2'd2) begin
                    r_d.ramRe = 1'b1;
                    r_d.ramAddr = r_q.ptr;
                    r_d.state = S_FWAIT;
                end
            end
            S_FWAIT: begin
                if (ramRvalid) begin
                    tot = r_q.txTotal;
                    if (r_q.txIdx == 6'd0) begin
                        wc = wordCount(ramRdata);
                        r_d.cmd1 = ramRdata;
                        tot = rtrt ? 6'd2 : 6'd1 + dataCount(ramRdata, isMode, legacy, 1'b1);
                        r_d.txTotal = tot;
                        r_d.rxData = rtrt ? wc : dataCount(ramRdata, isMode, legacy, 1'b0);
                        if (rtrt)
                            r_d.rxTotal = 6'd1 + wc + (bcast ? 6'd0 : 6'd1);
                        else
                            r_d.rxTotal = bcast ? 6'd0
                                : 6'd1 + dataCount(ramRdata, isMode, legacy, 1'b0);
                    end
                    if (r_q.txIdx == 6'd1 && rtrt)
                        r_d.cmd2 = ramRdata;
                    pushWord.cmdSync = (r_q.txIdx == 6'd0) || (rtrt && r_q.txIdx == 6'd1);
                    pushWord.data = ramRdata;
                    if (r_d.bufCnt == 2'd0)
                        r_d.buf0 = pushWord;
                    else
                        r_d.buf1 = pushWord;
                    r_d.bufCnt = r_d.bufCnt + 2'd1;
                    r_d.lastTx = ramRdata;
                    r_d.ptr = r_q.ptr + 16'd1;
                    r_d.txIdx = r_q.txIdx + 6'd1;
                    r_d.state = (r_q.txIdx + 6'd1 == tot) ? S_ECHO : S_FETCH;
                end
            end
            S_ECHO: begin
                if (r_q.echoCnt == r_q.txTotal)
                    r_d.state = S_LOOPWR;
            end
            S_LOOPWR: begin
                r_d.ramWe = 1'b1;
                r_d.ramAddr = r_q.ptr;
                r_d.ramWdata = r_q.lastEcho;
                r_d.ptr = r_q.ptr + 16'd1;
                r_d.state = (r_q.rxTotal == 6'd0) ? S_END : S_RX;
            end
            S_RX: begin
                if (rxWord.valid) begin
                    r_d.ramWe = 1'b1;
                    r_d.ramAddr = r_q.ptr;
                    r_d.ramWdata = rxWord.data;
                    r_d.ptr = r_q.ptr + 16'd1;
                    r_d.rxIdx = r_q.rxIdx + 6'd1;
                    isStat = (r_q.rxIdx == 6'd0)
                        || (rtrt && !bcast && r_q.rxIdx + 6'd1 == r_q.rxTotal);
                    if (isStat) begin
                        // transmitting RT answers first in RT-to-RT
                        ev = statusEval(rxWord.data,
                            (rtrt && r_q.rxIdx == 6'd0) ? r_q.cmd2 : r_q.cmd1,
                            r_q.ctrl, cfg, ext);
                        r_d.sSet = r_q.sSet || ev[2];
                        r_d.mSet = r_q.mSet || ev[1];
                        r_d.wAddr = r_q.wAddr || ev[0];
                        r_d.msgErr = r_q.msgErr || rxWord.data[`STS_MSG_ERR];
                    end
                    if (rxWord.cmdSync != isStat)
                        r_d.syncErr = 1'b1;
                    if (rxWord.invalid)
                        r_d.invWord = 1'b1;
                    r_d.fmtErr = r_d.fmtErr || ev[0] || rxWord.invalid
                        || (rxWord.cmdSync != isStat);
                    if (r_q.rxIdx + 6'd1 == r_q.rxTotal)
                        r_d.state = S_END;
                end else if (rspTimeout) begin
                    // a short reply after the first status is a count error
                    r_d.tmo = (r_q.rxIdx == 6'd0);
                    r_d.wcErr = (r_q.rxIdx != 6'd0);
                    r_d.fmtErr = r_q.fmtErr || (r_q.rxIdx != 6'd0);
                    r_d.state = S_END;
                end
            end
            S_END: begin
                if (retryOk) begin
                    r_d.chanA = r_q.ctrl[`CTRL_CHAN_A] ^ cfg.retryAltChan[r_q.retries[0]];
                    r_d.retries = r_q.retries + 2'd1;
                    r_d.state = S_SOM;
                end else begin
                    r_d.state = S_BSW;
                end
            end
            S_BSW: begin
                bsw[`BSW_END_OF_MESSAGE_FLAG] = 1'b1;
                bsw[`BSW_CHAN_B] = !r_q.chanA;
                bsw[`BSW_ERROR] = r_q.fmtErr || r_q.tmo || r_q.loopFail;
                bsw[`BSW_STATUS_SET] = r_q.sSet;
                bsw[`BSW_FORMAT_ERR] = r_q.fmtErr;
                bsw[`BSW_TIMEOUT] = r_q.tmo;
                bsw[`BSW_LOOP_FAIL] = r_q.loopFail;
                if (cfg.enhancedMode) begin
                    bsw[`BSW_FILTERED_STATUS_FLAG] = r_q.mSet;
                    bsw[`BSW_RETRY_CNT1] = r_q.retries[1];
                    bsw[`BSW_RETRY_CNT0] = r_q.retries[0];
                    bsw[`BSW_GOOD_BLOCK] = (r_q.rxData != 6'd0)
                        && !(r_q.fmtErr || r_q.tmo || r_q.wcErr);
                    bsw[`BSW_WRONG_ADDR] = r_q.wAddr;
                    bsw[`BSW_WC_ERR] = r_q.wcErr;
                    bsw[`BSW_SYNC_ERR] = r_q.syncErr;
                    bsw[`BSW_INVALID_WORD] = r_q.invWord;
                end else begin
                    bsw[7:0] = `BSW_LOW_LEGACY;
                end
                r_d.ramWe = 1'b1;
                r_d.ramAddr = r_q.desc;
                r_d.ramWdata = bsw;
                r_d.done = 1'b1;
                r_d.irq = ext && r_q.ctrl[`CTRL_MSG_END_IRQ_ENABLE] && cfg.msgIrqMaskBit;
                r_d.busy = 1'b0;
                r_d.inhibit = 1'b0;
                r_d.state = S_IDLE;
            end
            default: r_d.state = S_IDLE;
        endcase
        // the decoder echoes every sent word; last one is compared bit by bit
        if (rxWord.valid && r_q.echoCnt != r_q.txTotal
            && (r_q.state == S_FETCH || r_q.state == S_FWAIT || r_q.state == S_ECHO)) begin
            r_d.echoCnt = r_q.echoCnt + 6'd1;
            r_d.lastEcho = rxWord.data;
            if (rxWord.invalid
                || (r_q.echoCnt + 6'd1 == r_q.txTotal && rxWord.data != r_q.lastTx))
                r_d.loopFail = 1'b1;
        end
        r_d.txValid = (r_d.bufCnt != 2'd0);
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n)
            r_q <= '0;
        else
            r_q <= r_d;
    end

    assign ramRe = r_q.ramRe;
    assign ramWe = r_q.ramWe;
    assign ramAddr = r_q.ramAddr;
    assign ramWdata = r_q.ramWdata;
    assign txValid = r_q.txValid;
    assign txWord = r_q.buf0;
    assign txChanA = r_q.chanA;
    assign txInhibit = r_q.inhibit;
    assign busy = r_q.busy;
    assign msgDone = r_q.done;
    assign irqReq = r_q.irq;

    sequence somWrite;
        ramWe && ramWdata[`BSW_START_OF_MESSAGE_FLAG];
    endsequence

    sequence loopWrite;
        ramWe ##0 (ramWdata == $past(r_q.lastEcho));
    endsequence

    a_som_desc_addr: assert property (@(posedge clk_sys) disable iff (!reset_n)
        somWrite |-> (ramAddr == r_q.desc && !ramWdata[`BSW_END_OF_MESSAGE_FLAG]))
        else $error("start flag written outside descriptor");

    a_loop_word_store: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (r_q.state == S_LOOPWR) |=> loopWrite ##0 (ramAddr == r_q.base + {10'h000, r_q.txTotal} + 16'd1))
        else $error("loopback word misplaced");

    a_first_cmd_fetch: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ramRe && r_q.state == S_FWAIT && r_q.txIdx == 6'd0) |-> ramAddr == r_q.base + 16'd1)
        else $error("command word not read after control word");

    a_first_chan: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (somWrite and (r_q.retries == 2'd0)) |-> ramWdata[`BSW_CHAN_B] == !r_q.ctrl[`CTRL_CHAN_A])
        else $error("first attempt on wrong channel");

    a_selftest_quiet: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(txValid) |-> txInhibit == r_q.ctrl[`CTRL_SELF_TEST])
        else $error("transmitter inhibit does not follow self-test bit");

    a_retry_bound: assert property (@(posedge clk_sys) disable iff (!reset_n)
        msgDone |-> r_q.retries <= (cfg.doubleRetry ? 2'd2 : 2'd1))
        else $error("too many retries");

    a_irq_gate: assert property (@(posedge clk_sys) disable iff (!reset_n)
        irqReq |-> msgDone && $past(cfg.msgIrqMaskBit) && r_q.ctrl[`CTRL_MSG_END_IRQ_ENABLE])
        else $error("interrupt without enable and mask");

    a_bsw_fields: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (msgDone && $past(cfg.enhancedMode)) |-> ramWe
            && ramWdata[`BSW_END_OF_MESSAGE_FLAG] && !ramWdata[`BSW_START_OF_MESSAGE_FLAG]
            && ramWdata[`BSW_RETRY_CNT1:`BSW_RETRY_CNT0] == r_q.retries)
        else $error("block status word fields wrong");

endmodule : bc_message_control

// [tb/rt_bus_model.sv]
`timescale 1ns/1ps
module rt_bus_model
    import bc_msg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic ramRe,
    input wire logic ramWe,
    input wire logic [15:0] ramAddr,
    input wire logic [15:0] ramWdata,
    output logic [15:0] ramRdata,
    output logic ramRvalid,
    input wire logic txValid,
    input wire bus_word_t txWord,
    output logic txReady,
    output rx_word_t rxWord,
    output logic rspTimeout,
    input wire logic replyOn,
    input wire logic [15:0] stsWord
);
    logic [15:0] mem [0:255];
    bus_word_t echo [$];
    bus_word_t e;
    logic [3:0] idle = 4'h0;
    logic armed = 1'b0;
    initial begin
        ramRdata = 16'h0000;
        ramRvalid = 1'b0;
        txReady = 1'b0;
        rxWord = '0;
        rspTimeout = 1'b0;
    end
    always @(posedge clk_sys) begin
        ramRvalid <= ramRe;
        // idle read data flips so a late sample never looks valid
        ramRdata <= ramRe ? mem[ramAddr[7:0]] : ~ramRdata;
        if (ramWe) begin
            mem[ramAddr[7:0]] <= ramWdata;
        end
        // encoder stalls every other cycle to keep the buffer full
        txReady <= ~txReady;
        rspTimeout <= 1'b0;
        rxWord <= {3'b000, ~rxWord.data};
        if (txValid && txReady) begin
            echo.push_back(txWord);
            armed <= 1'b1;
            idle <= 4'h0;
        end else if (echo.size() != 0) begin
            e = echo.pop_front();
            rxWord <= {1'b1, e.cmdSync, 1'b0, e.data};
        end else if (armed) begin
            idle <= idle + 4'h1;
            if (idle == 4'hf) begin
                armed <= 1'b0;
                if (replyOn) begin
                    rxWord <= {2'b11, 1'b0, stsWord};
                end else begin
                    rspTimeout <= 1'b1;
                end
            end
        end
    end
endmodule : rt_bus_model

// [tb/bc_message_control_tb_top.sv]
`timescale 1ns/1ps
module bc_message_control_tb_top
    import bc_msg_pkg::*;
;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic start = 1'b0;
    logic [15:0] msgAddr = 16'h0010;
    logic [15:0] descAddr = 16'h0040;
    cfg_t cfg = '0;
    logic replyOn = 1'b0;
    logic [15:0] stsWord = 16'h0000;
    logic ramRe, ramWe, ramRvalid, txValid, txReady, txChanA, txInhibit;
    logic rspTimeout, busy, msgDone, irqReq;
    logic [15:0] ramAddr, ramWdata, ramRdata;
    bus_word_t txWord;
    rx_word_t rxWord;
    int fails = 0;
    int compares = 0;
    always #12.5 clk_sys = ~clk_sys;
    bc_message_control dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .start(start),
        .msgAddr(msgAddr), .descAddr(descAddr), .cfg(cfg), .ramRe(ramRe), .ramWe(ramWe),
        .ramAddr(ramAddr), .ramWdata(ramWdata), .ramRdata(ramRdata),
        .ramRvalid(ramRvalid), .txValid(txValid), .txWord(txWord), .txReady(txReady),
        .txChanA(txChanA), .txInhibit(txInhibit), .rxWord(rxWord),
        .rspTimeout(rspTimeout), .busy(busy), .msgDone(msgDone), .irqReq(irqReq));
    rt_bus_model mdl_u (.clk_sys(clk_sys), .ramRe(ramRe), .ramWe(ramWe),
        .ramAddr(ramAddr), .ramWdata(ramWdata), .ramRdata(ramRdata),
        .ramRvalid(ramRvalid), .txValid(txValid), .txWord(txWord), .txReady(txReady),
        .rxWord(rxWord), .rspTimeout(rspTimeout), .replyOn(replyOn), .stsWord(stsWord));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict
    // one receive message: command, one data word, status-only reply
    task automatic run(input cfg_t c, input logic [15:0] ctrl, input logic [15:0] sts,
            input logic rep, input logic [15:0] bsw, input logic irq);
        int n;
        logic ch;
        logic inh;
        logic irqSeen;
        logic [15:0] d;
        logic [15:0] lb;
        d = 16'h1200 ^ ctrl;
        // unused formats send nothing, so the loopback slot keeps its marker
        lb = (ctrl[2:0] == 3'h5 || ctrl[2:0] == 3'h7) ? ~d : d;
        ch = ctrl[7];
        inh = ctrl[6];
        irqSeen = 1'b0;
        n = 0;
        mdl_u.mem[16] = ctrl;
        mdl_u.mem[17] = 16'h2821;
        mdl_u.mem[18] = d;
        mdl_u.mem[19] = ~d;
        @(posedge clk_sys);
        cfg <= c;
        replyOn <= rep;
        stsWord <= sts;
        start <= 1'b1;
        @(posedge clk_sys);
        start <= 1'b0;
        while (msgDone !== 1'b1 && n < 400) begin
            @(posedge clk_sys);
            #1;
            if (txValid === 1'b1) begin
                ch = txChanA;
                inh = txInhibit;
            end
            irqSeen = irqReq;
            n++;
        end
        if (n >= 400) begin
            fails++;
            print_verdict();
        end
        @(posedge clk_sys);
        #1;
        check(mdl_u.mem[64], bsw);
        check({15'h0, irqSeen}, {15'h0, irq});
        check({15'h0, ch}, {15'h0, !bsw[13]});
        check({15'h0, inh}, {15'h0, ctrl[6]});
        check({15'h0, busy}, 16'h0000);
        check(mdl_u.mem[19], lb);
        if (rep) begin
            check(mdl_u.mem[20], sts);
        end
        $display("test with control %h done", ctrl);
    endtask : run
    initial begin
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        run(10'h000, 16'h0080, 16'h2800, 1'b1, 16'h80ff, 1'b0);
        run(10'h000, 16'h0000, 16'h2810, 1'b1, 16'ha8ff, 1'b0);
        run(10'h000, 16'h0020, 16'h2810, 1'b1, 16'ha0ff, 1'b0);
        run(10'h000, 16'h00c0, 16'h2800, 1'b1, 16'h80ff, 1'b0);
        run(10'h000, 16'h0080, 16'h2800, 1'b0, 16'h92ff, 1'b0);
        run(10'h303, 16'h00b0, 16'h2810, 1'b1, 16'h8000, 1'b1);
        run(10'h303, 16'h0080, 16'h2810, 1'b1, 16'h8880, 1'b0);
        run(10'h000, 16'h0085, 16'h2800, 1'b0, 16'h94ff, 1'b0);
        run(10'h390, 16'h0180, 16'h2800, 1'b0, 16'hb220, 1'b0);
        run(10'h000, 16'h0082, 16'h2800, 1'b0, 16'h80ff, 1'b0);
        print_verdict();
    end
endmodule : bc_message_control_tb_top
